/* File: core/ssp_slave.sv */
// Synchronous slave serial port with an AXI4-Lite register slave.
// Contract
// - Transmitter runs only while transmit allow is set; set before loading.
// - Ninth-bit option gives 9-bit characters; ninth data bit written first.
// - Writing the low byte to the holding register starts a transmission.
// - Continuous receive stays set in slave receive; receiver never idles.
// - Single receive bit has no effect on slave reception.
// - Receiving works in sleep; completed word moves to receive data.
// - Completed receive with its enable and the peripheral enable set wakes the device; branches with global.
// - Receive pending flag set on complete character; interrupt when enabled.
// - Ninth receive bit read from status first, then low byte from buffer.
// - Overrun cleared by clearing continuous receive or port on; latter resets port.
// - Only synchronous slave mode keeps shifting during sleep.
// - Shift registers are clocked by the external clock, not an internal one.
// - In sleep the port accepts data and clock on the link pins.
// - A full word clocked in during sleep sets pending flag and wakes.
// - After wake, resume after sleep; with global enable enter vector 004h.
// - Data changes on the leading clock edge, sampled on trailing edge.
// - Device never drives the clock pin in slave mode.
// - Two-character receive buffer; third sets overrun, keeps data, blocks.
`include "ssp_consts.svh"

module ssp_slave #(
  parameter int DATA_W = 9
) (
  input  wire logic        aclk,          // System clock
  input  wire logic        aresetn,       // Synchronous reset, active low
  input  wire logic [7:0]  s_awaddr,      // Write address
  input  wire logic        s_awvalid,     // Write address valid
  output logic             s_awready,     // Write address ready
  input  wire logic [31:0] s_wdata,       // Write data
  input  wire logic [3:0]  s_wstrb,       // Write byte enables
  input  wire logic        s_wvalid,      // Write data valid
  output logic             s_wready,      // Write data ready
  output logic [1:0]       s_bresp,       // Write response
  output logic             s_bvalid,      // Write response valid
  input  wire logic        s_bready,      // Write response ready
  input  wire logic [7:0]  s_araddr,      // Read address
  input  wire logic        s_arvalid,     // Read address valid
  output logic             s_arready,     // Read address ready
  output logic [31:0]      s_rdata,       // Read data
  output logic [1:0]       s_rresp,       // Read response
  output logic             s_rvalid,      // Read data valid
  input  wire logic        s_rready,      // Read data ready
  input  wire logic        sleep_i,       // Device is asleep
  input  wire logic        link_clock_in, // Clock pin level
  output logic             link_clock_out,// Clock pin drive value
  output logic             link_clock_oen,// Clock pin enable, low drives
  input  wire logic        link_data_in,  // Data pin level
  output logic             link_data_out, // Data pin drive value
  output logic             link_data_oen, // Data pin enable, low drives
  output logic             wake_o,        // Wake request from peripheral
  output logic             irq_o          // Branch to the interrupt vector
);
  // =============================================================
  // Control registers
  logic [7:0] intctl_q;
  logic [7:0] periph_irq_enable_one_q;
  logic       serial_port_on_q, rx9_q, single_rx_on_q, continuous_rx_on_q;
  logic       clock_source_master_q, tx9_q, tx_allow_q, sync_q, tx_ninth_data_q;
  logic       overrun_flag_q;
  logic [DATA_W-1:0] hold_q;
  logic       hold_full_q;
  logic [DATA_W-1:0] tsr_q;
  logic [3:0] tx_cnt_q;
  logic       tx_first_q;
  ssp_pkg::ssp_tx_state_type tx_st_q;
  logic [DATA_W-1:0] rsr_q;
  logic [3:0] rx_cnt_q;
  logic [DATA_W-1:0] fifo_q [2];
  logic [1:0] fcnt_q;
  logic       ck_s1_q, ck_s2_q, ck_s3_q;
  logic       dt_s1_q, dt_s2_q;
  logic       dout_q;

  // =============================================================
  // Bus slave state
  logic        aw_have_q, w_have_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic        w_lane0_q;
  logic        bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `SSP_OFS_RXTOP);
  endfunction

  function automatic logic [3:0] char_bits(input logic nine);
    char_bits = nine ? `SSP_BITS_9 : `SSP_BITS_8;
  endfunction

  // =============================================================
  // Mode decode
  logic slave_on, rx_mode, tx_mode, ck_rise, ck_fall;
  logic wr_do, rd_do, rd_pop, txh_wr, rx_done, tx_load;
  logic [7:0] periph_irq_flags_one_v, rxcs_v, txcs_v, baud_v, rd_v;

  assign slave_on = serial_port_on_q & sync_q & ~clock_source_master_q;
  // Single receive bit is a don't-care here
  assign rx_mode  = slave_on & continuous_rx_on_q;
  assign tx_mode  = slave_on & ~continuous_rx_on_q & ~single_rx_on_q & tx_allow_q;
  // Edges of the sampled link clock; only slave mode shifts, asleep or not
  assign ck_rise  = ck_s2_q & ~ck_s3_q;
  assign ck_fall  = ~ck_s2_q & ck_s3_q;

  // =============================================================
  // Pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      dt_s1_q <= 1'b0;
      dt_s2_q <= 1'b0;
    end else begin
      ck_s1_q <= link_clock_in;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      dt_s1_q <= link_data_in;
      dt_s2_q <= dt_s1_q;
    end
  end

  // Clock pin is input only; data pin driven only when transmitting
  assign link_clock_out = 1'b0;
  assign link_clock_oen = 1'b1;
  assign link_data_out  = dout_q;
  assign link_data_oen  = ~(tx_mode && tx_st_q == ssp_pkg::TX_SHIFT);

  // =============================================================
  // Bus handshakes
  assign s_awready = ~aw_have_q & ~bvalid_q;
  assign s_wready  = ~w_have_q & ~bvalid_q;
  assign s_arready = ~rvalid_q;
  assign s_bvalid  = bvalid_q;
  assign s_bresp   = bresp_q;
  assign s_rvalid  = rvalid_q;
  assign s_rresp   = rresp_q;
  assign s_rdata   = rdata_q;
  assign wr_do     = aw_have_q & w_have_q & ~bvalid_q;
  assign rd_do     = s_arvalid & s_arready;
  assign rd_pop    = rd_do && s_araddr == `SSP_OFS_RXTOP && fcnt_q != 2'h0;
  assign txh_wr    = wr_do && w_lane0_q && aw_addr_q == `SSP_OFS_TXHOLD;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `SSP_RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_have_q  <= 1'b1;
        w_data_q  <= s_wdata;
        w_lane0_q <= s_wstrb[0];
      end
      if (wr_do) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= mapped(aw_addr_q) ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      end else if (bvalid_q && s_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // =============================================================
  // Read data
  assign periph_irq_flags_one_v = {2'b00, fcnt_q != 2'h0, ~hold_full_q, 4'h0};
  assign rxcs_v = {serial_port_on_q, rx9_q, single_rx_on_q, continuous_rx_on_q, 2'b00, overrun_flag_q,
                   fifo_q[0][DATA_W-1]};
  assign txcs_v = {clock_source_master_q, tx9_q, tx_allow_q, sync_q, 2'b00,
                   tx_st_q == ssp_pkg::TX_IDLE, tx_ninth_data_q};
  assign baud_v = {1'b0, ~rx_mode, 6'h00};

  always_comb begin
    case (s_araddr)
      `SSP_OFS_INTCTL: rd_v = intctl_q;
      `SSP_OFS_PERIPH_IRQ_ENABLE_ONE:   rd_v = periph_irq_enable_one_q;
      `SSP_OFS_PERIPH_IRQ_FLAGS_ONE:   rd_v = periph_irq_flags_one_v;
      `SSP_OFS_RXCS:   rd_v = rxcs_v;
      `SSP_OFS_TXHOLD: rd_v = hold_q[7:0];
      `SSP_OFS_TXCS:   rd_v = txcs_v;
      `SSP_OFS_BAUD:   rd_v = baud_v;
      `SSP_OFS_RXTOP:  rd_v = fifo_q[0][7:0];
      default:         rd_v = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `SSP_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (rd_do) begin
      rvalid_q <= 1'b1;
      rresp_q  <= mapped(s_araddr) ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      rdata_q  <= {24'h00_0000, rd_v};
    end else if (rvalid_q && s_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // =============================================================
  // Software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      intctl_q <= `SSP_RST_BYTE;
      periph_irq_enable_one_q   <= `SSP_RST_BYTE;
      {serial_port_on_q, rx9_q, single_rx_on_q, continuous_rx_on_q} <= 4'h0;
      {clock_source_master_q, tx9_q, tx_allow_q, sync_q, tx_ninth_data_q} <= 5'h00;
    end else if (wr_do && w_lane0_q) begin
      case (aw_addr_q)
        `SSP_OFS_INTCTL: intctl_q <= {w_data_q[7:6], 6'h00};
        `SSP_OFS_PERIPH_IRQ_ENABLE_ONE:   periph_irq_enable_one_q   <= {2'b00, w_data_q[5:4], 4'h0};
        `SSP_OFS_RXCS: begin
          serial_port_on_q <= w_data_q[`SSP_B_SERIAL_PORT_ON];
          rx9_q  <= w_data_q[`SSP_B_RX9];
          single_rx_on_q <= w_data_q[`SSP_B_SINGLE_RX_ON];
          continuous_rx_on_q <= w_data_q[`SSP_B_CONTINUOUS_RX_ON];
        end
        `SSP_OFS_TXCS: begin
          clock_source_master_q <= w_data_q[`SSP_B_CLOCK_SOURCE_MASTER];
          tx9_q  <= w_data_q[`SSP_B_TX9];
          tx_allow_q <= w_data_q[`SSP_B_TX_ALLOW];
          sync_q <= w_data_q[`SSP_B_SYNC];
          tx_ninth_data_q <= w_data_q[`SSP_B_TX_NINTH_DATA];
        end
        default: begin
        end
      endcase
    end
  end

  // =============================================================
  // Transmit holding register
  assign tx_load = hold_full_q && tx_st_q == ssp_pkg::TX_IDLE && tx_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn || !serial_port_on_q) begin
      hold_q      <= '0;
      hold_full_q <= 1'b0;
    end else if (txh_wr && tx_allow_q && !hold_full_q) begin
      // Ninth bit comes from the status register written beforehand
      hold_q      <= {tx_ninth_data_q, w_data_q[7:0]};
      hold_full_q <= 1'b1;
    end else if (tx_load) begin
      hold_full_q <= 1'b0;
    end
  end

  // =============================================================
  // Transmit shifter: next bit on leading edge, counted on trailing edge
  always_ff @(posedge aclk) begin
    if (!aresetn || !serial_port_on_q) begin
      tx_st_q    <= ssp_pkg::TX_IDLE;
      tsr_q      <= '0;
      tx_cnt_q   <= 4'h0;
      tx_first_q <= 1'b0;
      dout_q     <= 1'b0;
    end else begin
      case (tx_st_q)
        ssp_pkg::TX_IDLE: begin
          if (tx_load) begin
            tsr_q      <= hold_q;
            dout_q     <= hold_q[0];
            tx_cnt_q   <= 4'h0;
            tx_first_q <= 1'b1;
            tx_st_q    <= ssp_pkg::TX_SHIFT;
          end
        end
        ssp_pkg::TX_SHIFT: begin
          if (!tx_mode) begin
            tx_st_q <= ssp_pkg::TX_IDLE;
          end else if (ck_rise) begin
            tx_first_q <= 1'b0;
            if (!tx_first_q) begin
              tsr_q  <= tsr_q >> 1;
              dout_q <= tsr_q[1];
            end
          end else if (ck_fall) begin
            // One clock per data bit
            if (tx_cnt_q + 4'h1 == char_bits(tx9_q)) begin
              tx_st_q <= ssp_pkg::TX_IDLE;
            end
            tx_cnt_q <= tx_cnt_q + 4'h1;
          end
        end
        default: tx_st_q <= ssp_pkg::TX_IDLE;
      endcase
    end
  end

  // =============================================================
  // Receive shifter, sampled on the trailing edge
  assign rx_done = rx_mode && !overrun_flag_q && ck_fall &&
                   rx_cnt_q + 4'h1 == char_bits(rx9_q);

  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_mode) begin
      rsr_q    <= '0;
      rx_cnt_q <= 4'h0;
    end else if (ck_fall && !overrun_flag_q) begin
      rsr_q    <= {dt_s2_q, rsr_q[DATA_W-1:1]};
      rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
    end
  end

  // Align an 8-bit character so bit 0 lands at the bottom
  logic [DATA_W-1:0] rx_word;
  assign rx_word = rx9_q ? {dt_s2_q, rsr_q[DATA_W-1:1]}
                         : {1'b0, dt_s2_q, rsr_q[DATA_W-1:2]};

  // =============================================================
  // Two-entry receive buffer and overrun
  always_ff @(posedge aclk) begin
    if (!aresetn || !serial_port_on_q) begin
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
      fcnt_q    <= 2'h0;
    end else begin
      if (rd_pop) begin
        fifo_q[0] <= fifo_q[1];
      end
      // A pop in the same cycle frees the slot that a full buffer lacks
      if (rx_done && (fcnt_q != `SSP_FIFO_DEPTH || rd_pop)) begin
        if (rd_pop ? fcnt_q == 2'h1 : fcnt_q == 2'h0) begin
          fifo_q[0] <= rx_word;
        end else begin
          fifo_q[1] <= rx_word;
        end
        if (!rd_pop) begin
          fcnt_q <= fcnt_q + 2'h1;
        end
      end else if (rd_pop) begin
        fcnt_q <= fcnt_q - 2'h1;
      end
    end
  end

  // A word that completes in the cycle the buffer is read still fits
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_mode) begin
      overrun_flag_q <= 1'b0;
    end else if (rx_done && fcnt_q == `SSP_FIFO_DEPTH && !rd_pop) begin
      overrun_flag_q <= 1'b1;
    end
  end

  // =============================================================
  // Wake and interrupt
  // Pending flag follows buffer contents, so it wakes from sleep as well
  assign wake_o = intctl_q[`SSP_B_PERIPH_IRQ_ALLOW] &
                  ((periph_irq_enable_one_q[`SSP_B_RX_IRQ_ALLOW] & (fcnt_q != 2'h0)) |
                   (periph_irq_enable_one_q[`SSP_B_TX_IRQ_ALLOW] & ~hold_full_q));
  // Without global enable execution simply resumes after sleep
  assign irq_o  = wake_o & intctl_q[`SSP_B_GIE];

endmodule // ssp_slave

/* File: core/ssp_consts.svh */
// Register offsets, bit positions and reset values of the serial port.
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
// =============================================================
// Register byte offsets
`define SSP_OFS_INTCTL   8'h00
`define SSP_OFS_PERIPH_IRQ_ENABLE_ONE     8'h04
`define SSP_OFS_PERIPH_IRQ_FLAGS_ONE     8'h08
`define SSP_OFS_RXCS     8'h0c
`define SSP_OFS_TXHOLD   8'h10
`define SSP_OFS_TXCS     8'h14
`define SSP_OFS_BAUD     8'h18
`define SSP_OFS_RXTOP    8'h1c
// =============================================================
// Field positions
`define SSP_B_GIE        7
`define SSP_B_PERIPH_IRQ_ALLOW       6
`define SSP_B_RX_IRQ_ALLOW       5
`define SSP_B_TX_IRQ_ALLOW       4
`define SSP_B_RX_PENDING_FLAG       5
`define SSP_B_TX_FREE_FLAG       4
`define SSP_B_SERIAL_PORT_ON       7
`define SSP_B_RX9        6
`define SSP_B_SINGLE_RX_ON       5
`define SSP_B_CONTINUOUS_RX_ON       4
`define SSP_B_OVERRUN_FLAG       1
`define SSP_B_RX_NINTH_DATA       0
`define SSP_B_CLOCK_SOURCE_MASTER       7
`define SSP_B_TX9        6
`define SSP_B_TX_ALLOW       5
`define SSP_B_SYNC       4
`define SSP_B_TRMT       1
`define SSP_B_TX_NINTH_DATA       0
`define SSP_B_RCIDL      6
// =============================================================
// Reset values and counts
`define SSP_RST_BYTE     8'h00
`define SSP_BITS_8       4'h8
`define SSP_BITS_9       4'h9
`define SSP_FIFO_DEPTH   2'h2
`define SSP_RESP_OKAY    2'h0
`define SSP_RESP_SLVERR  2'h2
`endif

/* File: core/ssp_pkg.sv */
// Types shared by the serial port design.
package ssp_pkg;
  typedef enum logic {
    TX_IDLE,
    TX_SHIFT
  } ssp_tx_state_type;
endpackage

/* File: verification/ssp_slave_assertions.sv */
// Concurrent checks on the serial port's bus handshakes and pin outputs.
module ssp_slave_checker (
  input wire logic        aclk,           // System clock
  input wire logic        aresetn,        // Synchronous reset, active low
  input wire logic        s_awvalid,      // Write address valid
  input wire logic        s_awready,      // Write address ready
  input wire logic        s_wvalid,       // Write data valid
  input wire logic        s_wready,       // Write data ready
  input wire logic        s_bvalid,       // Write response valid
  input wire logic        s_bready,       // Write response ready
  input wire logic        s_arvalid,      // Read address valid
  input wire logic        s_arready,      // Read address ready
  input wire logic [31:0] s_rdata,        // Read data
  input wire logic        s_rvalid,       // Read data valid
  input wire logic        s_rready,       // Read data ready
  input wire logic        link_clock_oen, // Clock pin enable
  input wire logic        link_data_oen,  // Data pin enable
  input wire logic        wake_o,         // Wake request
  input wire logic        irq_o           // Vector branch request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // =============================================================
  // Pins and wake-up
  property p_clk_undriven;
    link_clock_oen;
  endproperty
  a_clk_undriven: assert property (p_clk_undriven) else $error("clock pin driven");
  property p_irq_wake;
    irq_o |-> wake_o;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("vector without wake");
  property p_reset_quiet;
    $rose(aresetn) |-> !s_bvalid && !s_rvalid && link_data_oen && !wake_o && s_arready;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  // =============================================================
  // Register bus
  property p_bresp;
    s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");
  property p_b_once;
    s_bvalid && s_bready |=> !s_bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write response repeated");
  property p_rvalid;
    s_arvalid && s_arready |=> s_rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read data late");
  property p_r_once;
    s_rvalid && s_rready |=> !s_rvalid;
  endproperty
  a_r_once: assert property (p_r_once) else $error("read data repeated");
  property p_rdata_top;
    s_rvalid |-> s_rdata[31:8] == 24'h0;
  endproperty
  a_rdata_top: assert property (p_rdata_top) else $error("read data upper bits set");
  property p_ar_block;
    s_rvalid |-> !s_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");
endmodule // ssp_slave_checker

bind ssp_slave ssp_slave_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_bready(s_bready),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid),
  .s_rready(s_rready), .link_clock_oen(link_clock_oen), .link_data_oen(link_data_oen),
  .wake_o(wake_o), .irq_o(irq_o));

/* File: verification/ssp_link_master.sv */
// Behavioural external master that clocks characters through the slave port.
module ssp_link_master (
  output logic      link_clock, // Shift clock to the slave, idle low
  output logic      link_data,  // Master data drive
  input  wire logic data_pin    // Resolved data pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    link_clock = 1'b0;
    link_data = 1'b0;
  end
  // Exactly n clocks per character; half period hp sets fast or slow pacing
  task automatic xfer(input logic [8:0] v, input int n, input int hp, output logic [8:0] got);
    got = 9'h000;
    #37;
    for (int i = 0; i < n; i++) begin
      link_clock = 1'b1;
      link_data = v[i];
      #hp;
      link_clock = 1'b0;
      got[i] = data_pin;
      #hp;
    end
    // Released line must not keep showing the last bit
    link_data = ~link_data;
  endtask
endmodule // ssp_link_master

/* File: verification/ssp_slave_tb.sv */
// Self-checking bench for the synchronous slave serial port.
`include "ssp_consts.svh"
module ssp_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, awv, wv, br, arv, rr, sleep;
  logic        awr, wrdy, bv, arr, rv, cko, ckoe, dout, doen, wake, irq, lclk, mdat;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [8:0]  v, w, g;
  logic [7:0]  q [3];
  int          errors, checked, cyc;
  int unsigned seed = 32;
  // Link pins are purely digital here, no analog selection to turn off
  wire         cpin = ckoe ? lclk : cko;
  wire         dpin = doen ? mdat : dout;

  ssp_slave #(.DATA_W(9)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awv), .s_awready(awr),
    .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wv), .s_wready(wrdy), .s_bresp(bresp),
    .s_bvalid(bv), .s_bready(br), .s_araddr(araddr), .s_arvalid(arv), .s_arready(arr),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rv), .s_rready(rr), .sleep_i(sleep),
    .link_clock_in(cpin), .link_clock_out(cko), .link_clock_oen(ckoe),
    .link_data_in(dpin), .link_data_out(dout), .link_data_oen(doen),
    .wake_o(wake), .irq_o(irq));
  ssp_link_master u_m (.link_clock(lclk), .link_data(mdat), .data_pin(dpin));

  // =============================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] pir(input logic r, input logic t);
    return {2'b00, r, t, 4'h0};
  endfunction
  function automatic logic [1:0] resp_exp(input logic [7:0] a);
    return (a[1:0] != 2'h0 || a > `SSP_OFS_RXTOP) ? `SSP_RESP_SLVERR : `SSP_RESP_OKAY;
  endfunction
  task automatic stop_test();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bus cycles: ready sampled at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, t;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awv & awr;
      tw = wv & wrdy;
      t = bv;
      r = bresp;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!t);
    br <= 1'b0;
    chk($sformatf("bresp %h", a), 9'(r), 9'(resp_exp(a)));
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic ta, t;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arv & arr;
      t = rv;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
    end while (!t);
    rr <= 1'b0;
    chk($sformatf("rresp %h", a), 9'(r), 9'(resp_exp(a)));
    chk($sformatf("rdata %h", a), 9'(d), 9'(e));
  endtask
  // Flag needs a few system clocks to cross from the link side
  task automatic rx(input logic [8:0] c, input int n, input int hp);
    u_m.xfer(c, n, hp, g);
    repeat (8) @(posedge aclk);
  endtask

  // =============================================================
  // Clock, timeout and main sequence
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    {aresetn, awv, wv, br, arv, rr, sleep} = 7'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'h1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SSP_OFS_INTCTL, 8'h00);
    rd(`SSP_OFS_RXCS, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h02, 8'hff);
    wr(`SSP_OFS_TXCS, 8'h10);
    wr(`SSP_OFS_RXCS, 8'hb0);
    wr(`SSP_OFS_PERIPH_IRQ_ENABLE_ONE, 8'h20);
    sleep <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      v = 9'(xs());
      wr(`SSP_OFS_INTCTL, {1'(k != 1), 7'h40});
      rx(v, 8, (k & 1) ? 1200 : 400);
      chk("wake", 9'(wake), 9'h1);
      chk("irq", 9'(irq), 9'(k != 1));
      rd(`SSP_OFS_PERIPH_IRQ_FLAGS_ONE, pir(1'b1, 1'b1));
      rd(`SSP_OFS_RXTOP, v[7:0]);
      @(negedge aclk);
      chk("wake idle", 9'(wake), 9'h0);
    end
    for (int k = 0; k < 3; k++) begin
      q[k] = 8'(xs());
      rx(9'(q[k]), 8, 400);
    end
    rd(`SSP_OFS_RXCS, 8'hb2);
    rx(9'h0a5, 8, 400);
    rd(`SSP_OFS_RXTOP, q[0]);
    rd(`SSP_OFS_RXTOP, q[1]);
    rd(`SSP_OFS_PERIPH_IRQ_FLAGS_ONE, pir(1'b0, 1'b1));
    wr(`SSP_OFS_RXCS, 8'h80);
    rd(`SSP_OFS_RXCS, 8'h80);
    wr(`SSP_OFS_RXCS, 8'hd0);
    v = 9'(xs());
    rx(v, 9, 400);
    rd(`SSP_OFS_RXCS, {7'h68, v[8]});
    rd(`SSP_OFS_RXTOP, v[7:0]);
    rx(v, 9, 400);
    wr(`SSP_OFS_RXCS, 8'h00);
    rd(`SSP_OFS_PERIPH_IRQ_FLAGS_ONE, pir(1'b0, 1'b1));
    wr(`SSP_OFS_RXCS, 8'h80);
    wr(`SSP_OFS_TXCS, 8'h50);
    wr(`SSP_OFS_TXHOLD, 8'h5a);
    rd(`SSP_OFS_PERIPH_IRQ_FLAGS_ONE, pir(1'b0, 1'b1));
    v = 9'(xs());
    w = {v[8], 8'(xs())};
    wr(`SSP_OFS_TXCS, {7'h38, v[8]});
    wr(`SSP_OFS_TXHOLD, v[7:0]);
    rd(`SSP_OFS_PERIPH_IRQ_FLAGS_ONE, pir(1'b0, 1'b1));
    wr(`SSP_OFS_TXHOLD, w[7:0]);
    rd(`SSP_OFS_PERIPH_IRQ_FLAGS_ONE, pir(1'b0, 1'b0));
    u_m.xfer(9'h000, 9, 400, g);
    chk("tx first", g, v);
    repeat (8) @(posedge aclk);
    rd(`SSP_OFS_PERIPH_IRQ_FLAGS_ONE, pir(1'b0, 1'b1));
    u_m.xfer(9'h1ff, 9, 1200, g);
    chk("tx second", g, w);
    repeat (8) @(posedge aclk);
    chk("data enable", 9'(doen), 9'h1);
    chk("clock enable", 9'(ckoe), 9'h1);
    rd(`SSP_OFS_TXCS, {7'h39, v[8]});
    rd(`SSP_OFS_TXHOLD, w[7:0]);
    rd(`SSP_OFS_BAUD, 8'h40);
    chk("tx wake off", 9'(wake), 9'h0);
    wr(`SSP_OFS_PERIPH_IRQ_ENABLE_ONE, 8'h10);
    chk("tx wake", 9'(wake), 9'h1);
    chk("tx irq", 9'(irq), 9'h1);
    stop_test();
  end
endmodule // ssp_slave_tb
